// [rtl/csg_pkg.sv]
package csg_pkg;

    // clock and reference rates
    localparam int unsigned CLK_MHZ       = 25;
    localparam int unsigned REF_MHZ       = 2;
    localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int unsigned REF_ACC_W     = 5;

    // one-shot widths for the capstan A and B pulses, rounded up to whole cycles
    localparam int unsigned CAP_A_NS  = 2000;
    localparam int unsigned CAP_B_NS  = 1000;
    localparam int unsigned CAP_A_CYC = (CAP_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CAP_B_CYC = (CAP_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SHOT_W    = 8;

    // counters
    localparam int unsigned SPD_W            = 8;
    localparam int unsigned GAP_W            = 7;
    localparam int unsigned GAP_BASE         = 48;
    localparam int unsigned GAP_HEAD_SPACING = 16;
    localparam logic [GAP_W-1:0] GAP_NOMINAL = GAP_W'(GAP_BASE + GAP_HEAD_SPACING);
    localparam logic [SPD_W-1:0] SPD_MAX     = 8'hFF;

    // register map, byte addresses
    localparam int unsigned   ADDR_W      = 12;
    localparam logic [11:0]   ADDR_CTRL   = 12'h000;
    localparam logic [11:0]   ADDR_PRESET = 12'h004;
    localparam logic [11:0]   ADDR_STATUS = 12'h008;
    localparam logic [11:0]   ADDR_GAP    = 12'h00C;

    // field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_MODE_MSB = 1;
    localparam int unsigned CTRL_DIR_BIT  = 2;
    localparam int unsigned CTRL_GATE_BIT = 3;
    localparam int unsigned ST_FAST_BIT   = 0;
    localparam int unsigned ST_OVF_BIT    = 1;
    localparam int unsigned ST_THREAD_BIT = 2;
    localparam int unsigned ST_WRITE_BIT  = 3;
    localparam int unsigned ST_NOM_BIT    = 4;
    localparam int unsigned ST_CNT_LSB    = 8;
    localparam int unsigned ST_CNT_MSB    = 15;

    // reset values
    localparam logic [SPD_W-1:0] PRESET_RST = 8'h80;
    localparam logic             DIR_RST    = 1'b0;
    localparam logic             GATE_RST   = 1'b0;

    typedef enum logic [1:0] {
        CSG_MODE_STOP,
        CSG_MODE_RUN,
        CSG_MODE_MAX
    } csg_mode_t;

    typedef struct packed {
        logic fwd;
        logic rev;
        logic brake;
    } csg_drive_t;

    localparam csg_drive_t DRIVE_BRAKE = '{fwd: 1'b0, rev: 1'b0, brake: 1'b1};

    // pins that need synchronising, one bit each
    typedef struct packed {
        logic tach;
        logic reel;
        logic thread;
        logic write;
    } csg_pins_t;

endpackage : csg_pkg

// [rtl/csg_one_shot.sv]
`timescale 1ns/100ps
`default_nettype none

module csg_one_shot #(
    parameter int unsigned WIDTH_CYC = 1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic trig,
    output var  logic q
);

    localparam logic [csg_pkg::SHOT_W-1:0] LOAD = csg_pkg::SHOT_W'(WIDTH_CYC);

    logic [csg_pkg::SHOT_W-1:0] cnt_reg;

    // retriggerable: a new edge restarts the full width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            q       <= 1'b0;
        end else if (trig) begin
            cnt_reg <= LOAD;
            q       <= 1'b1;
        end else if (cnt_reg > csg_pkg::SHOT_W'(1)) begin
            cnt_reg <= cnt_reg - csg_pkg::SHOT_W'(1);
        end else begin
            cnt_reg <= '0;
            q       <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_shot_fires: assert property (trig |=> q ##1 q)
        else $error("one-shot did not fire on trigger");

endmodule : csg_one_shot

`default_nettype wire

// [rtl/csg_gap_speed.sv]
`timescale 1ns/100ps
`default_nettype none

module csg_gap_speed (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [csg_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output var  logic [31:0]                   prdata,
    output var  logic                          pready,
    output var  logic                          pslverr,
    input  wire logic                          tach_pin,
    input  wire logic                          reel_marker_pin,
    input  wire logic                          thread_status_pin,
    input  wire logic                          write_active_pin,
    output var  csg_pkg::csg_drive_t           drive,
    output var  logic                          capstan_a,
    output var  logic                          capstan_b,
    output var  logic                          capstan_fast,
    output var  logic [csg_pkg::GAP_W-1:0]     block_gap_count,
    output var  logic                          block_gap_nominal
);

    // ---------------- pin synchronisers ----------------
    localparam int unsigned NPIN = $bits(csg_pkg::csg_pins_t);

    logic [NPIN-1:0]       pin_raw;
    logic [NPIN-1:0]       pin_meta_reg;
    logic [NPIN-1:0]       pin_sync_reg;
    logic [NPIN-1:0]       pin_last_reg;
    csg_pkg::csg_pins_t    pin_lvl;
    csg_pkg::csg_pins_t    pin_rise;

    assign pin_raw  = {tach_pin, reel_marker_pin, thread_status_pin, write_active_pin};
    assign pin_lvl  = csg_pkg::csg_pins_t'(pin_sync_reg);
    assign pin_rise = csg_pkg::csg_pins_t'(pin_sync_reg & ~pin_last_reg);

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                    pin_last_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= pin_raw[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                    pin_last_reg[gi] <= pin_sync_reg[gi];
                end
            end
        end
    endgenerate

    // ---------------- capstan A and B one-shots ----------------
    logic cap_a_last_reg;
    logic cap_b_last_reg;
    logic tach_evt;
    logic cap_b_evt;

    csg_one_shot #(
        .WIDTH_CYC (csg_pkg::CAP_A_CYC)
    ) u_shot_a (
        .pclk    (pclk),
        .presetn (presetn),
        .trig    (pin_rise.tach),
        .q       (capstan_a)
    );

    csg_one_shot #(
        .WIDTH_CYC (csg_pkg::CAP_B_CYC)
    ) u_shot_b (
        .pclk    (pclk),
        .presetn (presetn),
        .trig    (pin_rise.tach),
        .q       (capstan_b)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_a_last_reg <= 1'b0;
            cap_b_last_reg <= 1'b0;
        end else begin
            cap_a_last_reg <= capstan_a;
            cap_b_last_reg <= capstan_b;
        end
    end

    // a retrigger keeps the shot high, so count the tach edge itself
    assign tach_evt  = pin_rise.tach & capstan_a & cap_a_last_reg | capstan_a & ~cap_a_last_reg;
    assign cap_b_evt = capstan_b & ~cap_b_last_reg;

    // ---------------- 2 MHz reference enable ----------------
    // fractional divider: 25 MHz has no integer ratio to 2 MHz, so ticks
    // alternate 12 and 13 cycles apart and average exactly 2 MHz
    localparam logic [csg_pkg::REF_ACC_W-1:0] ACC_STEP = csg_pkg::REF_ACC_W'(csg_pkg::REF_MHZ);
    localparam logic [csg_pkg::REF_ACC_W-1:0] ACC_MOD  = csg_pkg::REF_ACC_W'(csg_pkg::CLK_MHZ);

    logic [csg_pkg::REF_ACC_W-1:0] ref_acc_reg;
    logic [csg_pkg::REF_ACC_W-1:0] ref_acc_sum;
    logic                          ref_tick;

    assign ref_acc_sum = ref_acc_reg + ACC_STEP;
    assign ref_tick    = (ref_acc_sum >= ACC_MOD);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_acc_reg <= '0;
        end else if (ref_tick) begin
            ref_acc_reg <= ref_acc_sum - ACC_MOD;
        end else begin
            ref_acc_reg <= ref_acc_sum;
        end
    end

    // ---------------- control registers ----------------
    csg_pkg::csg_mode_t            mode_reg;
    logic                          dir_rev_reg;
    logic                          gate_en_reg;
    logic [csg_pkg::SPD_W-1:0]     preset_reg;
    logic                          wr_take;
    logic                          gap_clr;

    assign wr_take = psel & penable & pready & pwrite & ~pslverr;
    assign gap_clr = wr_take & (paddr == csg_pkg::ADDR_GAP);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg    <= csg_pkg::CSG_MODE_STOP;
            dir_rev_reg <= csg_pkg::DIR_RST;
            gate_en_reg <= csg_pkg::GATE_RST;
        end else if (wr_take && paddr == csg_pkg::ADDR_CTRL) begin
            mode_reg    <= csg_pkg::csg_mode_t'(pwdata[csg_pkg::CTRL_MODE_MSB:csg_pkg::CTRL_MODE_LSB]);
            dir_rev_reg <= pwdata[csg_pkg::CTRL_DIR_BIT];
            gate_en_reg <= pwdata[csg_pkg::CTRL_GATE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preset_reg <= csg_pkg::PRESET_RST;
        end else if (wr_take && paddr == csg_pkg::ADDR_PRESET) begin
            preset_reg <= pwdata[csg_pkg::SPD_W-1:0];
        end
    end

    // ---------------- speed reference counter ----------------
    logic [csg_pkg::SPD_W-1:0] spd_cnt_reg;
    logic                      ovf_seen_reg;
    logic                      ovf_evt;

    assign ovf_evt = ref_tick & (spd_cnt_reg == csg_pkg::SPD_MAX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_cnt_reg <= csg_pkg::PRESET_RST;
        end else if (tach_evt) begin
            spd_cnt_reg <= preset_reg;
        end else if (ref_tick) begin
            spd_cnt_reg <= spd_cnt_reg + csg_pkg::SPD_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_seen_reg <= 1'b1;
        end else if (tach_evt) begin
            ovf_seen_reg <= 1'b0;
        end else if (ovf_evt) begin
            ovf_seen_reg <= 1'b1;
        end
    end

    // an overflow landing on the same edge as the pulse counts as late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capstan_fast <= 1'b0;
        end else if (tach_evt) begin
            capstan_fast <= ~(ovf_seen_reg | ovf_evt);
        end else if (ovf_evt) begin
            capstan_fast <= 1'b0;
        end
    end

    // ---------------- armature drive ----------------
    csg_pkg::csg_drive_t drive_next;
    logic                accel;

    always_comb begin
        accel      = 1'b0;
        drive_next = csg_pkg::DRIVE_BRAKE;
        unique case (mode_reg)
            csg_pkg::CSG_MODE_STOP: accel = 1'b0;
            csg_pkg::CSG_MODE_RUN:  accel = ~capstan_fast;
            csg_pkg::CSG_MODE_MAX:  accel = 1'b1;
            default:                accel = 1'b0;
        endcase
        if (mode_reg == csg_pkg::CSG_MODE_RUN || mode_reg == csg_pkg::CSG_MODE_MAX) begin
            // coast leaves both sides open; stop and the unused mode 3 ground the armature
            drive_next.brake = 1'b0;
            drive_next.fwd   = accel & ~dir_rev_reg;
            drive_next.rev   = accel & dir_rev_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= csg_pkg::DRIVE_BRAKE;
        end else begin
            drive <= drive_next;
        end
    end

    // ---------------- block gap counter ----------------
    logic                      gap_step;
    logic [csg_pkg::GAP_W-1:0] gap_next;

    // threading takes priority; capstan pulses are ignored meanwhile
    assign gap_step = pin_lvl.thread ? pin_rise.reel
                                     : (cap_b_evt & pin_lvl.write & gate_en_reg);
    assign gap_next = gap_clr  ? '0 :
                      gap_step ? block_gap_count + csg_pkg::GAP_W'(1) : block_gap_count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_gap_count   <= '0;
            block_gap_nominal <= 1'b0;
        end else begin
            block_gap_count   <= gap_next;
            block_gap_nominal <= (gap_next >= csg_pkg::GAP_NOMINAL);
        end
    end

    // ---------------- APB slave ----------------
    // no wait states: read data is registered in the setup cycle
    logic        addr_ok;
    logic [31:0] rd_mux;

    assign addr_ok = (paddr == csg_pkg::ADDR_CTRL) || (paddr == csg_pkg::ADDR_PRESET)
                  || (paddr == csg_pkg::ADDR_STATUS) || (paddr == csg_pkg::ADDR_GAP);

    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            csg_pkg::ADDR_CTRL: begin
                rd_mux[csg_pkg::CTRL_MODE_MSB:csg_pkg::CTRL_MODE_LSB] = mode_reg;
                rd_mux[csg_pkg::CTRL_DIR_BIT]  = dir_rev_reg;
                rd_mux[csg_pkg::CTRL_GATE_BIT] = gate_en_reg;
            end
            csg_pkg::ADDR_PRESET: rd_mux[csg_pkg::SPD_W-1:0] = preset_reg;
            csg_pkg::ADDR_STATUS: begin
                rd_mux[csg_pkg::ST_FAST_BIT]   = capstan_fast;
                rd_mux[csg_pkg::ST_OVF_BIT]    = ovf_seen_reg;
                rd_mux[csg_pkg::ST_THREAD_BIT] = pin_lvl.thread;
                rd_mux[csg_pkg::ST_WRITE_BIT]  = pin_lvl.write;
                rd_mux[csg_pkg::ST_NOM_BIT]    = block_gap_nominal;
                rd_mux[csg_pkg::ST_CNT_MSB:csg_pkg::ST_CNT_LSB] = spd_cnt_reg;
            end
            csg_pkg::ADDR_GAP: rd_mux[csg_pkg::GAP_W-1:0] = block_gap_count;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && !penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~addr_ok;
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ref_tick_spacing: assert property (ref_tick |=> !ref_tick [*8])
        else $error("reference ticks closer than expected");

    chk_fast_early_pulse: assert property (
        tach_evt && !ovf_seen_reg && !ovf_evt |=> capstan_fast)
        else $error("early pulse did not flag fast");

    chk_slow_on_ovf: assert property (ovf_evt |=> !capstan_fast ##1 !ovf_seen_reg || !capstan_fast)
        else $error("overflow did not clear fast");

    chk_run_drive: assert property (
        mode_reg == csg_pkg::CSG_MODE_RUN && !dir_rev_reg |=>
        (drive.fwd == !$past(capstan_fast)) && !drive.rev && !drive.brake)
        else $error("run drive not following fast flag");

    chk_max_speed: assert property (
        mode_reg == csg_pkg::CSG_MODE_MAX && dir_rev_reg |=> drive.rev && !drive.fwd)
        else $error("maximum speed drive missing");

    chk_stop_brake: assert property (
        mode_reg == csg_pkg::CSG_MODE_STOP |=> drive.brake && !drive.fwd && !drive.rev)
        else $error("stop did not brake");

    chk_spd_restart: assert property (tach_evt |=> spd_cnt_reg == $past(preset_reg))
        else $error("speed counter not restarted");

    chk_thread_count: assert property (
        pin_lvl.thread && pin_rise.reel && !gap_clr |=>
        block_gap_count == $past(block_gap_count) + csg_pkg::GAP_W'(1))
        else $error("reel marker not counted");

    chk_write_gated: assert property (
        !pin_lvl.thread && !(pin_lvl.write && gate_en_reg) && !gap_clr |=> $stable(block_gap_count))
        else $error("gap counted while ungated");

    chk_gap_wrap: assert property (
        block_gap_count == '1 && gap_step && !gap_clr |=> block_gap_count == '0)
        else $error("gap counter not seven stages");

    chk_gap_nominal: assert property (
        block_gap_count == csg_pkg::GAP_NOMINAL |-> block_gap_nominal)
        else $error("nominal gap flag missing");

    cov_fast_pulse:  cover property (tach_evt ##1 capstan_fast);
    cov_slow_ovf:    cover property (capstan_fast ##1 ovf_evt ##1 !capstan_fast);
    cov_gap_nominal: cover property ($rose(block_gap_nominal));
    cov_thread_step: cover property (pin_lvl.thread && pin_rise.reel);

endmodule : csg_gap_speed

`default_nettype wire

// [testbench/csg_capstan_model.sv]
`timescale 1ns/100ps
`default_nettype none

module csg_capstan_model (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [15:0]         period,
    input  wire csg_pkg::csg_drive_t drive,
    output var  logic                tach_pin,
    output var  logic                drive_fault
);
    logic [15:0] cnt_reg;

    // squared tach pulse, four cycles high; period 0 parks the capstan
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= 16'h0000;
            tach_pin <= 1'b0;
        end else if (period == 16'h0000) begin
            cnt_reg  <= 16'h0000;
            tach_pin <= 1'b0;
        end else begin
            cnt_reg  <= (cnt_reg >= period - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
            tach_pin <= (cnt_reg < 16'h0004);
        end
    end

    // both polarities at once, or current while braking, shorts the armature
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            drive_fault <= 1'b0;
        else if ((drive.fwd && drive.rev) || (drive.brake && (drive.fwd || drive.rev)))
            drive_fault <= 1'b1;
    end
endmodule : csg_capstan_model

`default_nettype wire

// [testbench/csg_gap_speed_test.sv]
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module csg_gap_speed_test;
    typedef struct packed {
        logic [1:0]  mode;
        logic        dir;
        logic [7:0]  preset;
        logic [15:0] per;
        logic        fast;
        logic [2:0]  drv;
    } csg_row_t;

    logic                      pclk, presetn, psel, penable, pwrite;
    logic [11:0]               paddr;
    logic [31:0]               pwdata, prdata, q;
    logic                      pready, pslverr, e, tach_pin, drive_fault, b_prev;
    logic                      reel_marker_pin, thread_status_pin, write_active_pin;
    csg_pkg::csg_drive_t       drive;
    logic                      capstan_a, capstan_b, capstan_fast, block_gap_nominal;
    logic [6:0]                block_gap_count, v;
    logic [15:0]               tach_period;
    int                        bad_count, samples_checked, b_rises, b_base, la, lb, n;

    // preset 0xF0 overflows after 16 ticks, about 200 cycles
    csg_row_t rows [8] = '{
        '{2'h1, 1'h0, 8'hF0, 16'h0064, 1'h1, 3'h0},
        '{2'h1, 1'h0, 8'hF0, 16'h0190, 1'h0, 3'h4},
        '{2'h1, 1'h1, 8'hF0, 16'h0190, 1'h0, 3'h2},
        '{2'h1, 1'h0, 8'hFF, 16'h0064, 1'h0, 3'h4},
        '{2'h2, 1'h0, 8'hF0, 16'h0064, 1'h1, 3'h4},
        '{2'h2, 1'h1, 8'hF0, 16'h0064, 1'h1, 3'h2},
        '{2'h0, 1'h0, 8'hF0, 16'h0064, 1'h1, 3'h1},
        '{2'h3, 1'h1, 8'hF0, 16'h0064, 1'h1, 3'h1}
    };

    csg_gap_speed u_csg_gap_speed (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tach_pin(tach_pin), .reel_marker_pin(reel_marker_pin),
        .thread_status_pin(thread_status_pin), .write_active_pin(write_active_pin),
        .drive(drive), .capstan_a(capstan_a), .capstan_b(capstan_b),
        .capstan_fast(capstan_fast), .block_gap_count(block_gap_count),
        .block_gap_nominal(block_gap_nominal)
    );

    csg_capstan_model u_csg_capstan_model (
        .pclk(pclk), .presetn(presetn), .period(tach_period), .drive(drive),
        .tach_pin(tach_pin), .drive_fault(drive_fault)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (capstan_b === 1'b1 && b_prev !== 1'b1)
            b_rises++;
        b_prev <= capstan_b;
    end

    task close_out;
        $display("mismatches %0d, compares %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task tick(input int c);
        repeat (c) @(posedge pclk);
    endtask : tick

    // request held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin bad_count++; close_out(); end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_gap(input logic [6:0] t);
        int k;
        k = 0;
        while (block_gap_count !== t && k < 20000) begin @(posedge pclk); k++; end
        if (k >= 20000) begin bad_count++; close_out(); end
        tick(1);
    endtask : wait_gap

    initial begin
        #4000000;
        bad_count++;
        close_out();
    end

    initial begin
        {psel, penable, pwrite, presetn, reel_marker_pin, b_prev} = '0;
        {thread_status_pin, write_active_pin, paddr, pwdata, tach_period} = '0;
        tick(6);
        presetn <= 1'b1;
        tick(1);
        `CHK(drive, csg_pkg::DRIVE_BRAKE)
        `CHK(capstan_fast, 1'b0)
        `CHK(block_gap_count, 7'h00)
        `CHK(block_gap_nominal, 1'b0)
        apb(1'b0, csg_pkg::ADDR_CTRL, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, csg_pkg::ADDR_PRESET, 32'h0);
        `CHK(q[7:0], csg_pkg::PRESET_RST)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({e, q}, 33'h100000000)
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        `CHK(e, 1'b1)
        foreach (rows[i]) begin
            apb(1'b1, csg_pkg::ADDR_PRESET, {24'h0, rows[i].preset});
            apb(1'b1, csg_pkg::ADDR_CTRL, {29'h0, rows[i].dir, rows[i].mode});
            tach_period <= rows[i].per;
            tick(2000);
            `CHK(capstan_fast, rows[i].fast)
            `CHK(drive, rows[i].drv)
        end
        apb(1'b0, csg_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[csg_pkg::ST_FAST_BIT], 1'b1)
        // one-shot widths, period 100 leaves the window free of retriggers
        // start from a low shot so the window holds a whole pulse
        n = 0;
        while (capstan_a !== 1'b0 && n < 200) begin @(posedge pclk); n++; end
        while (capstan_a !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
        if (n >= 200) begin bad_count++; close_out(); end
        la = 0;
        lb = 0;
        repeat (60) begin
            la += int'(capstan_a === 1'b1);
            lb += int'(capstan_b === 1'b1);
            @(posedge pclk);
        end
        `CHK(la, int'(csg_pkg::CAP_A_CYC))
        `CHK(lb, int'(csg_pkg::CAP_B_CYC))
        // threading wins over armed write counting while tach keeps running
        write_active_pin  <= 1'b1;
        thread_status_pin <= 1'b1;
        apb(1'b1, csg_pkg::ADDR_CTRL, 32'h9);
        apb(1'b1, csg_pkg::ADDR_GAP, 32'h0);
        repeat (6) begin
            reel_marker_pin <= 1'b1;
            tick(4);
            reel_marker_pin <= 1'b0;
            tick(4);
        end
        tick(6);
        `CHK(block_gap_count, 7'h06)
        apb(1'b0, csg_pkg::ADDR_GAP, 32'h0);
        `CHK(q[6:0], 7'h06)
        thread_status_pin <= 1'b0;
        apb(1'b1, csg_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, csg_pkg::ADDR_GAP, 32'h0);
        tick(600);
        `CHK(block_gap_count, 7'h00)
        tach_period <= 16'h0000;
        tick(100);
        b_base = b_rises;
        apb(1'b1, csg_pkg::ADDR_CTRL, 32'h9);
        tach_period <= 16'h003C;
        wait_gap(7'h3F);
        `CHK(block_gap_nominal, 1'b0)
        wait_gap(7'h40);
        `CHK(block_gap_nominal, 1'b1)
        `CHK(block_gap_count, 7'(b_rises - b_base))
        wait_gap(7'h7F);
        wait_gap(7'h00);
        `CHK(block_gap_nominal, 1'b0)
        write_active_pin <= 1'b0;
        tick(10);
        v = block_gap_count;
        tick(300);
        `CHK(block_gap_count, v)
        // fault flag is cleared by reset, so look before it
        `CHK(drive_fault, 1'b0)
        // second reset in mid-run with the capstan turning
        presetn <= 1'b0;
        tick(2);
        `CHK(drive, csg_pkg::DRIVE_BRAKE)
        `CHK(block_gap_count, 7'h00)
        presetn <= 1'b1;
        apb(1'b0, csg_pkg::ADDR_CTRL, 32'h0);
        `CHK(q, 32'h0)
        `CHK(capstan_fast, 1'b0)
        `CHK(drive_fault, 1'b0)
        close_out();
    end
endmodule : csg_gap_speed_test

`default_nettype wire
